/* core/timer_pair_pkg.sv */
// constants for the cascadable 8-bit timer pair: register indices, fields, codes
// assumes a 32-bit axi4-lite slave, byte address = index * 4
package timer_pair_pkg;
  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_T3_CTL = 6'h1a;
  localparam logic [5:0] IDX_T4_CTL = 6'h1b;
  localparam logic [5:0] IDX_T3_PER = 6'h20;
  localparam logic [5:0] IDX_T3_PW = 6'h21;
  localparam logic [5:0] IDX_T4_PER = 6'h22;
  localparam logic [5:0] IDX_T4_PW = 6'h23;
  localparam logic [5:0] IDX_STATUS = 6'h24;
  localparam logic [5:0] IDX_CONFIG = 6'h25;
  // ****************************************************************
  // control fields and reset values
  // ****************************************************************
  localparam int CTL_FF = 7;
  localparam int CTL_CLK_HI = 6;
  localparam int CTL_CLK_LO = 4;
  localparam int CTL_RUN = 3;
  localparam int CTL_MODE_HI = 2;
  localparam int CFG_TAP = 0;
  localparam int CFG_LOW_SPEED = 1;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] CFG_RESET = 2'h0;
  // ****************************************************************
  // mode and clock codes
  // ****************************************************************
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_PDO = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_CASCADE = 3'h3;
  localparam logic [2:0] MODE16_TIMER = 3'h4;
  localparam logic [2:0] MODE16_WARM = 3'h5;
  localparam logic [2:0] MODE16_PWM = 3'h6;
  localparam logic [2:0] MODE16_PPG = 3'h7;
  localparam logic [2:0] CLK_SLOW_DIV = 3'h0;
  localparam logic [2:0] CLK_FS = 3'h4;
  localparam logic [2:0] CLK_FC = 3'h6;
  localparam logic [2:0] CLK_PIN = 3'h7;
  // ****************************************************************
  // dividers and bus answers
  // ****************************************************************
  localparam int DIV_W = 11;
  localparam int FS_DIV_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* core/timer_tick_select.sv */
// one timer's count-source selector with its own count pin synchroniser
// assumes sources are one-cycle enables on aclk; bit 7 of sources is unused
`timescale 1ns/1ns
module timer_tick_select
  import timer_pair_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] sources,
  input wire logic [2:0] clock_select,
  input wire logic low_speed,
  input wire logic warm_up_ok,
  input wire logic count_pin,
  output logic tick
);
  typedef struct packed {
    logic [2:0] sync;
    logic level;
  } sel_state_t;

  sel_state_t s;
  sel_state_t next_s;
  logic pin_rise;

  // a change counts only once stages two and three agree
  assign pin_rise = (s.sync[1] == s.sync[2]) && s.sync[2] && !s.level;

  always_comb
  begin
    next_s = s;
    next_s.sync = {s.sync[1:0], count_pin};
    if (s.sync[1] == s.sync[2])
    begin
      next_s.level = s.sync[2];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  always_comb
  begin
    tick = 1'b0;
    if (clock_select == CLK_PIN)
    begin
      tick = pin_rise;
    end
    else if (!low_speed)
    begin
      tick = sources[clock_select];
    end
    else if ((clock_select == CLK_SLOW_DIV) || (clock_select == CLK_FS))
    begin
      tick = sources[clock_select];
    end
    else if (clock_select == CLK_FC)
    begin
      tick = warm_up_ok;
    end
  end

  a_fc_every_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    (clock_select == CLK_FC) && !low_speed |-> tick)
    else $error("fc source did not tick every cycle");
  a_low_speed_block: assert property (@(posedge aclk) disable iff (!aresetn)
    low_speed && (clock_select inside {3'h1, 3'h2, 3'h3, 3'h5}) |-> !tick)
    else $error("forbidden source ticked in low-speed mode");
  a_pin_edge_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (clock_select == CLK_PIN) && tick |=> !tick)
    else $error("pin edge counted twice");
endmodule

/* core/timer_pair_ctrl.sv */
// control logic of a cascadable pair of 8-bit timer/counters, axi4-lite slave
// assumes aclk is the high-frequency clock; slow clock and count pins are async
`timescale 1ns/1ns
// Overview of operation
// - control register resets to zero: ff bit7, clock 6-4, run 3, mode 2-0.
// - clock field picks divided fc, fs, fs/8 with tap option, or count pin.
// - low-speed modes allow only codes 000, 100, 110 for warm-up, and 111 count pin.
// - run bit low stops and clears counter; high counts the selected source.
// - mode field: timer, divider output, pwm, or cascaded 16-bit.
// - cascade uses timer3 clock, timer4 run bit and timer4 ff bit.
// - pulse width rewritable while running only in pwm modes.
// - each timer has control, period and pulse-width registers.
// - timer4 mode top bit set makes timer3 overflow its source.
// - timer4 16-bit codes: 100 timer, 101 warm-up, 110 pwm, 111 ppg.
module timer_pair_ctrl
  import timer_pair_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [timer_pair_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [timer_pair_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_freq_clock,
  input wire logic timer3_count_pin,
  input wire logic timer4_count_pin,
  output logic timer3_ff_out,
  output logic timer4_ff_out
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic w_held;
    logic [5:0] wr_idx;
    logic [7:0] wr_data;
    logic wr_lane;
    logic [7:0] timer3_control;
    logic [7:0] timer4_control;
    logic [7:0] timer3_period_value;
    logic [7:0] timer4_period_value;
    logic [7:0] timer3_pulse_width_value;
    logic [7:0] timer4_pulse_width_value;
    logic [7:0] pw_buf3;
    logic [7:0] pw_buf4;
    logic [1:0] config_bits;
    logic [DIV_W-1:0] div;
    logic [2:0] fs_sync;
    logic fs_level;
    logic [FS_DIV_W-1:0] fs_div;
    logic [7:0] cnt3;
    logic [7:0] cnt4;
    logic ff3;
    logic ff4;
  } pair_state_t;

  pair_state_t s;
  pair_state_t next_s;
  logic write_do;
  logic wr_ok;
  logic fs_tick;
  logic [7:0] sources;
  logic [2:0] mode3;
  logic [2:0] mode4;
  logic cascade;
  logic run3;
  logic run4;
  logic pwm3;
  logic pwm4;
  logic tick3;
  logic tick4_sel;
  logic tick4;
  logic ovf3;
  logic match3;
  logic match16;
  logic pw16_hit;

  // ****************************************************************
  // source clocks
  // ****************************************************************
  // slow clock edges are rare against aclk, so a filtered edge is a clean enable
  assign fs_tick = (s.fs_sync[1] == s.fs_sync[2]) && s.fs_sync[2] && !s.fs_level;
  assign sources[0] = s.config_bits[CFG_TAP] || s.config_bits[CFG_LOW_SPEED]
                      ? (fs_tick && (&s.fs_div)) : (&s.div[10:0]);
  assign sources[1] = &s.div[6:0];
  assign sources[2] = &s.div[4:0];
  assign sources[3] = &s.div[2:0];
  assign sources[4] = fs_tick;
  assign sources[5] = s.div[0];
  assign sources[6] = 1'b1;
  assign sources[7] = 1'b0;

  assign mode3 = s.timer3_control[CTL_MODE_HI:0];
  assign mode4 = s.timer4_control[CTL_MODE_HI:0];
  assign cascade = (mode3 == MODE_CASCADE);
  assign run3 = cascade ? s.timer4_control[CTL_RUN] : s.timer3_control[CTL_RUN];
  assign run4 = s.timer4_control[CTL_RUN];
  assign pwm3 = (mode3 == MODE_PWM);
  assign pwm4 = (mode4 == MODE_PWM) || (mode4 == MODE16_PWM);

  timer_tick_select u_sel3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .sources(sources),
    .clock_select(s.timer3_control[CTL_CLK_HI:CTL_CLK_LO]),
    .low_speed(s.config_bits[CFG_LOW_SPEED]),
    .warm_up_ok(cascade && (mode4 == MODE16_WARM)),
    .count_pin(timer3_count_pin),
    .tick(tick3)
  );

  timer_tick_select u_sel4 (
    .aclk(aclk),
    .aresetn(aresetn),
    .sources(sources),
    .clock_select(s.timer4_control[CTL_CLK_HI:CTL_CLK_LO]),
    .low_speed(s.config_bits[CFG_LOW_SPEED]),
    .warm_up_ok(mode4 == MODE16_WARM),
    .count_pin(timer4_count_pin),
    .tick(tick4_sel)
  );

  // ****************************************************************
  // compare events
  // ****************************************************************
  assign match3 = (s.cnt3 == s.timer3_period_value);
  assign match16 = ({s.cnt4, s.cnt3} == {s.timer4_period_value, s.timer3_period_value});
  assign pw16_hit = ({s.cnt4, s.cnt3} ==
                     {s.timer4_pulse_width_value, s.timer3_pulse_width_value});
  assign ovf3 = run3 && tick3 && (cascade ? ((s.cnt3 == 8'hff) && !match16) : match3);
  assign tick4 = mode4[2] ? ovf3 : tick4_sel;

  // ****************************************************************
  // register bus
  // ****************************************************************
  function automatic logic mapped(input logic [5:0] idx);
    mapped = idx inside {IDX_T3_CTL, IDX_T4_CTL, IDX_T3_PER, IDX_T3_PW,
                         IDX_T4_PER, IDX_T4_PW, IDX_STATUS, IDX_CONFIG};
  endfunction

  function automatic logic [31:0] read_word(input logic [5:0] idx);
    read_word = 32'h0;
    case (idx)
      IDX_T3_CTL: read_word = {24'h0, s.timer3_control};
      IDX_T4_CTL: read_word = {24'h0, s.timer4_control};
      IDX_T3_PER: read_word = {24'h0, s.timer3_period_value};
      IDX_T3_PW: read_word = {24'h0, s.timer3_pulse_width_value};
      IDX_T4_PER: read_word = {24'h0, s.timer4_period_value};
      IDX_T4_PW: read_word = {24'h0, s.timer4_pulse_width_value};
      IDX_STATUS: read_word = {14'h0, s.ff4, s.ff3, s.cnt4, s.cnt3};
      IDX_CONFIG: read_word = {30'h0, s.config_bits};
      default: read_word = 32'h0;
    endcase
  endfunction

  assign write_do = s.aw_held && s.w_held && !s.bvalid;
  assign wr_ok = write_do && s.wr_lane;

  always_comb
  begin
    next_s = s;
    next_s.div = s.div + 11'h001;
    next_s.fs_sync = {s.fs_sync[1:0], low_freq_clock};
    if (s.fs_sync[1] == s.fs_sync[2])
    begin
      next_s.fs_level = s.fs_sync[2];
    end
    if (fs_tick)
    begin
      next_s.fs_div = s.fs_div + 3'h1;
    end
    if (s.awready && s_axi_awvalid)
    begin
      next_s.aw_held = 1'b1;
      next_s.awready = 1'b0;
      next_s.wr_idx = s_axi_awaddr[7:2];
    end
    if (s.wready && s_axi_wvalid)
    begin
      next_s.w_held = 1'b1;
      next_s.wready = 1'b0;
      next_s.wr_data = s_axi_wdata[7:0];
      next_s.wr_lane = s_axi_wstrb[0];
    end
    if (write_do)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (s.arready && s_axi_arvalid)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = read_word(s_axi_araddr[7:2]);
      next_s.rresp = mapped(s_axi_araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    // period taken as written, software keeps it still while running
    if (wr_ok)
    begin
      case (s.wr_idx)
        IDX_T3_CTL: next_s.timer3_control = s.wr_data;
        IDX_T4_CTL: next_s.timer4_control = s.wr_data;
        IDX_T3_PER: next_s.timer3_period_value = s.wr_data;
        IDX_T4_PER: next_s.timer4_period_value = s.wr_data;
        IDX_T3_PW:
        begin
          if (!run3)
          begin
            next_s.timer3_pulse_width_value = s.wr_data;
          end
          if (!run3 || pwm3 || pwm4)
          begin
            next_s.pw_buf3 = s.wr_data;
          end
        end
        IDX_T4_PW:
        begin
          if (!run4)
          begin
            next_s.timer4_pulse_width_value = s.wr_data;
          end
          if (!run4 || pwm4)
          begin
            next_s.pw_buf4 = s.wr_data;
          end
        end
        IDX_CONFIG: next_s.config_bits = s.wr_data[1:0];
        default: ;
      endcase
    end
    // ****************************************************************
    // timer3 counter
    // ****************************************************************
    // stop clears counter
    if (!run3)
    begin
      next_s.cnt3 = 8'h00;
      next_s.ff3 = s.timer3_control[CTL_FF];
    end
    else if (tick3)
    begin
      if (cascade)
      begin
        next_s.cnt3 = match16 ? 8'h00 : s.cnt3 + 8'h01;
      end
      else if (match3)
      begin
        next_s.cnt3 = 8'h00;
        next_s.timer3_pulse_width_value = s.pw_buf3;
        if ((mode3 == MODE_PDO) || pwm3)
        begin
          next_s.ff3 = !s.ff3;
        end
      end
      else
      begin
        next_s.cnt3 = s.cnt3 + 8'h01;
        if (pwm3 && (s.cnt3 == s.timer3_pulse_width_value))
        begin
          next_s.ff3 = !s.ff3;
        end
      end
    end
    // ****************************************************************
    // timer4 counter
    // ****************************************************************
    // cascade ff level from timer4
    if (!run4)
    begin
      next_s.cnt4 = 8'h00;
      next_s.ff4 = s.timer4_control[CTL_FF];
    end
    else if (cascade && mode4[2] && tick3 && match16)
    begin
      next_s.cnt4 = 8'h00;
      next_s.timer3_pulse_width_value = s.pw_buf3;
      next_s.timer4_pulse_width_value = s.pw_buf4;
      if (mode4 != MODE16_TIMER)
      begin
        next_s.ff4 = !s.ff4;
      end
    end
    else if (tick4 && (mode4 != MODE_CASCADE))
    begin
      if (mode4[2])
      begin
        next_s.cnt4 = s.cnt4 + 8'h01;
        if (cascade && (mode4 inside {MODE16_PWM, MODE16_PPG}) && pw16_hit)
        begin
          next_s.ff4 = !s.ff4;
        end
      end
      else if (s.cnt4 == s.timer4_period_value)
      begin
        next_s.cnt4 = 8'h00;
        next_s.timer4_pulse_width_value = s.pw_buf4;
        if (mode4 != MODE_TIMER)
        begin
          next_s.ff4 = !s.ff4;
        end
      end
      else
      begin
        next_s.cnt4 = s.cnt4 + 8'h01;
        if (pwm4 && (s.cnt4 == s.timer4_pulse_width_value))
        begin
          next_s.ff4 = !s.ff4;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.timer3_control <= CTL_RESET;
      s.timer4_control <= CTL_RESET;
      s.config_bits <= CFG_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_arready = s.arready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign timer3_ff_out = s.ff3;
  assign timer4_ff_out = s.ff4;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_both_held;
    s.aw_held && s.w_held && !s.bvalid;
  endsequence
  sequence s_resp_up;
    s.bvalid ##1 1'b1;
  endsequence

  a_reset_ctl_zero: assert property (@(posedge aclk)
    $rose(aresetn) |-> (s.timer3_control == 8'h00) && (s.timer4_control == 8'h00))
    else $error("control registers not zero after reset");
  a_stop_clears_cnt: assert property (@(posedge aclk) disable iff (!aresetn)
    !run3 |=> (s.cnt3 == 8'h00))
    else $error("stopped timer3 counter not cleared");
  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    run3 && tick3 && !cascade && !match3 |=> (s.cnt3 == $past(s.cnt3) + 8'h01))
    else $error("timer3 did not advance by one");
  a_cascade_run: assert property (@(posedge aclk) disable iff (!aresetn)
    cascade && !s.timer4_control[CTL_RUN] |=> (s.cnt3 == 8'h00))
    else $error("cascade ignored timer4 run bit");
  a_t4_source: assert property (@(posedge aclk) disable iff (!aresetn)
    run4 && mode4[2] && !ovf3 && !(cascade && tick3) && !wr_ok |=> $stable(s.cnt4))
    else $error("timer4 moved without timer3 overflow");
  a_reserved_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    run4 && (mode4 == MODE_CASCADE) && !wr_ok |=> $stable(s.cnt4))
    else $error("timer4 counted in reserved mode");
  a_pw_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ok && (s.wr_idx == IDX_T3_PW) && run3 && !pwm3 && !pwm4 && !cascade
    |=> $stable(s.timer3_pulse_width_value) && $stable(s.pw_buf3))
    else $error("pulse width changed while running outside pwm");
  a_period_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ok && (s.wr_idx == IDX_T4_PER) |=> (s.timer4_period_value == $past(s.wr_data)))
    else $error("period write not stored");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_both_held |=> s_resp_up)
    else $error("write response missing");
  a_mode_cascade: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode3 == MODE_CASCADE) && run4 && mode4[2] && ovf3 && !match16 |=>
    (s.cnt4 == $past(s.cnt4) + 8'h01))
    else $error("cascade carry lost");
endmodule

/* verification/tb_eight_bit_timer_pair_control.sv */
// self-checking bench for the timer pair control block over axi4-lite
// assumes the design carries its own assertions; bench drives every port itself
`timescale 1ns/1ns
module tb_eight_bit_timer_pair_control;
  import timer_pair_pkg::*;
  // ****************************************************************
  // signals and instance
  // ****************************************************************
  localparam logic [7:0] A_T3C = {IDX_T3_CTL, 2'b00};
  localparam logic [7:0] A_T4C = {IDX_T4_CTL, 2'b00};
  localparam logic [7:0] A_T3P = {IDX_T3_PER, 2'b00};
  localparam logic [7:0] A_T3W = {IDX_T3_PW, 2'b00};
  localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [7:0] A_CFG = {IDX_CONFIG, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic fs = 1'b0;
  logic pin3 = 1'b0;
  logic pin4 = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ff3, ff4;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] b_q[$];
  logic [33:0] r_q[$];
  int mismatches = 0;
  int n_checks = 0;
  logic [7:0] addrs[8];
  logic [7:0] masks[8];
  logic [7:0] v;

  timer_pair_ctrl timer_pair_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .low_freq_clock(fs), .timer3_count_pin(pin3),
    .timer4_count_pin(pin4), .timer3_ff_out(ff3), .timer4_ff_out(ff4));

  always #2 aclk = ~aclk;
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // starts one edge late so no strobe is assigned twice in one step
  task automatic axi_write(input logic [7:0] addr, input logic [7:0] data,
    input logic [1:0] resp);
    @(posedge aclk);
    b_q.push_back(resp);
    awaddr <= addr;
    wdata <= {24'h0, data};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] addr, input logic [31:0] data,
    input logic [1:0] resp);
    @(posedge aclk);
    r_q.push_back({resp, data});
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
  endtask

  // slow pulses so every edge clears the pin synchronisers
  task automatic pulse(input int which, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      {fs, pin4, pin3} <= 3'b001 << which;
      repeat (6) @(posedge aclk);
      {fs, pin4, pin3} <= 3'b000;
      repeat (6) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
  endtask

  // ****************************************************************
  // result monitor
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (bvalid && bready)
      check({bresp, 32'h0}, {b_q.pop_front(), 32'h0});
    if (rvalid && rready)
      check({rresp, rdata}, r_q.pop_front());
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    close_out();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    addrs = '{A_T3P, A_T3W, A_T3P + 8'h08, A_T3W + 8'h08, A_ST, A_CFG, A_T3C, A_T4C};
    masks = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h03, 8'hf7, 8'hf7};
    void'($urandom(32'h7874));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (addrs[i]) axi_read(addrs[i], 32'h0, RESP_OKAY);
    axi_read(8'hfc, 32'h0, RESP_SLVERR);
    $display("test reset values done");
    // control written last: its ff bit would show in status
    foreach (addrs[i])
    begin
      v = 8'($urandom) & masks[i];
      // run bit is never set here, so nothing counts during readback
      axi_write(addrs[i], v | (~masks[i] & 8'hf7), RESP_OKAY);
      axi_read(addrs[i], {24'h0, v}, RESP_OKAY);
    end
    axi_write(8'hfc, 8'h5a, RESP_SLVERR);
    axi_write(A_T3C, 8'h00, RESP_OKAY);
    axi_write(A_T4C, 8'h00, RESP_OKAY);
    axi_write(A_CFG, 8'h00, RESP_OKAY);
    $display("test readback done");
    for (int t = 0; t < 2; t++)
    begin
      v = 8'(1 + $urandom % 5);
      axi_write(A_T3P + 8'(t * 8), 8'hff, RESP_OKAY);
      axi_write(A_T3C + 8'(t * 4), 8'h78, RESP_OKAY);
      pulse(t, v);
      axi_read(A_ST, t ? {16'h0, v, 8'h0} : {24'h0, v}, RESP_OKAY);
      axi_write(A_T3C + 8'(t * 4), 8'h70, RESP_OKAY);
      axi_read(A_ST, 32'h0, RESP_OKAY);
    end
    $display("test pin counting done");
    axi_write(A_T3P, 8'h02, RESP_OKAY);
    axi_write(A_T3C, 8'h79, RESP_OKAY);
    // match clears on the tick after the count reaches the period
    pulse(0, 2);
    axi_read(A_ST, 32'h0000_0002, RESP_OKAY);
    pulse(0, 1);
    axi_read(A_ST, 32'h0001_0000, RESP_OKAY);
    check({33'h0, ff3}, 34'h1);
    axi_write(A_T3C, 8'h71, RESP_OKAY);
    axi_read(A_ST, 32'h0, RESP_OKAY);
    axi_write(A_T3C, 8'hf0, RESP_OKAY);
    axi_read(A_ST, 32'h0001_0000, RESP_OKAY);
    check({33'h0, ff3}, 34'h1);
    axi_write(A_T3C, 8'h70, RESP_OKAY);
    $display("test divider output done");
    axi_write(A_T3W, 8'h12, RESP_OKAY);
    axi_write(A_T3C, 8'h78, RESP_OKAY);
    axi_write(A_T3W, 8'h55, RESP_OKAY);
    axi_read(A_T3W, 32'h12, RESP_OKAY);
    axi_write(A_T3C, 8'h70, RESP_OKAY);
    $display("test pulse width guard done");
    axi_write(A_T3P + 8'h08, 8'hff, RESP_OKAY);
    axi_write(A_T3C, 8'h73, RESP_OKAY);
    axi_write(A_T4C, 8'h6c, RESP_OKAY);
    pulse(0, 3);
    axi_read(A_ST, 32'h3, RESP_OKAY);
    axi_read(A_ST, 32'h3, RESP_OKAY);
    // timer3 wraps past 0xff and carries one into timer4
    pulse(0, 253);
    axi_read(A_ST, 32'h100, RESP_OKAY);
    axi_write(A_T4C, 8'h64, RESP_OKAY);
    axi_read(A_ST, 32'h0, RESP_OKAY);
    axi_write(A_T3C, 8'h70, RESP_OKAY);
    axi_write(A_T4C, 8'h6b, RESP_OKAY);
    repeat (20) @(posedge aclk);
    axi_read(A_ST, 32'h0, RESP_OKAY);
    axi_write(A_T4C, 8'h63, RESP_OKAY);
    $display("test cascade done");
    axi_write(A_CFG, 8'h02, RESP_OKAY);
    axi_write(A_T3P, 8'hff, RESP_OKAY);
    axi_write(A_T3C, 8'h48, RESP_OKAY);
    pulse(2, 3);
    axi_read(A_ST, 32'h3, RESP_OKAY);
    axi_write(A_T3C, 8'h40, RESP_OKAY);
    axi_write(A_T3C, 8'h18, RESP_OKAY);
    repeat (300) @(posedge aclk);
    axi_read(A_ST, 32'h0, RESP_OKAY);
    axi_write(A_T3C, 8'h10, RESP_OKAY);
    axi_write(A_T3C, 8'h68, RESP_OKAY);
    repeat (20) @(posedge aclk);
    axi_read(A_ST, 32'h0, RESP_OKAY);
    axi_write(A_T3C, 8'h60, RESP_OKAY);
    $display("test low speed done");
    repeat (2) @(posedge aclk);
    close_out();
  end
endmodule
